// [sw_power_ctrl.sv]
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// - pin low powers the whole chip down; release issues an internal reset.
// - mode field 00 normal, 01 energy detect, 10 soft down, 11 saving.
// - mode field returns to normal after power-up or any hardware reset.
// - normal mode runs clocks, all PHYs, MACs and the host interface.
// - from normal mode the host may select any other mode.
// - energy detect sleeps after no cable energy longer than the timeout.
// - low power state keeps only the receive energy detector alive.
// - cable energy in low power state returns to normal power state.
// - unplugged in low power state, emit a 120 ns pulse every second.
// - soft power-down stops clocks, PHYs and MACs.
// - any host access wakes soft power-down and resets all registers.
// - power saving needs autonegotiation on, cable off and mode 11.
// - power saving keeps clocks, MAC, registers and host access.
// - power saving keeps PHY transmit, drops unused receiver until activity.
// - from power saving the host may select any other mode.
// - port control bit 3 powers down that port's PHY alone.
// - management PHY power-down bit also powers down that port's PHY.
module sw_power_ctrl #(
  parameter int SECOND_CYC = sw_pwr_pkg::SECOND_CYC_DEF,
  parameter int SLEEP_UNIT_CYC = sw_pwr_pkg::SLEEP_UNIT_CYC_DEF
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input sw_pwr_pkg::wb_req_s i_wb,
  output sw_pwr_pkg::wb_rsp_s o_wb,
  input wire logic i_chip_sleep_pin_n,
  input wire logic [sw_pwr_pkg::NUM_PORTS-1:0] i_cable_energy,
  input wire logic [sw_pwr_pkg::NUM_PORTS-1:0] i_an_enable,
  output logic o_chip_power_en,
  output logic o_int_reset,
  output logic o_pll_en,
  output logic o_mac_en,
  output logic o_host_en,
  output logic o_energy_det_en,
  output logic o_link_pulse,
  output logic [sw_pwr_pkg::NUM_PORTS-1:0] o_phy_tx_en,
  output logic [sw_pwr_pkg::NUM_PORTS-1:0] o_phy_rx_en
);
  import sw_pwr_pkg::*;

  localparam logic [CNT_W-1:0] SEC_LAST = CNT_W'(SECOND_CYC - 1);
  localparam logic [CNT_W-1:0] UNIT_LAST = CNT_W'(SLEEP_UNIT_CYC - 1);

  state_s s;
  state_s next_s;
  pwr_mode_e mode_f;
  logic [7:0] wdata;
  logic [7:0] idx;
  logic req;
  logic commit;
  logic pin_hold;
  logic [NUM_PORTS-1:0] port_off;

  // ==========================================================
  // register defaults, shared by pin power-down and soft wake (hardware reset loads STATE_RST)
  function automatic state_s regs_default(input state_s x);
    state_s y;
    y = x;
    y.mode_reg = MODE_RST;
    y.sleep_reg = SLEEP_RST;
    y.port_ctl = '0;
    y.phy_pd = '0;
    y.unit_cnt = '0;
    y.sleep_cnt = '0;
    y.sec_cnt = '0;
    return y;
  endfunction

  assign mode_f = pwr_mode_e'(s.mode_reg[MODE_MSB:MODE_LSB]);
  assign wdata = i_wb.dat[7:0];
  assign idx = i_wb.adr[9:2];
  assign req = i_wb.cyc && i_wb.stb;
  // write lands on the edge at which the master sees ack
  assign commit = req && s.ack && i_wb.we && i_wb.sel[0] && s.st == ST_RUN;
  assign pin_hold = s.pin_level && s.pin_sync[2];

  // ==========================================================
  // next state
  always_comb begin
    next_s = s;
    next_s.pin_sync = {s.pin_sync[1:0], i_chip_sleep_pin_n};
    next_s.nrg_sync = {s.nrg_sync[1:0], i_cable_energy};
    // a change counts once the second and third stages agree
    if (s.pin_sync[1] == s.pin_sync[2]) begin
      next_s.pin_level = s.pin_sync[2];
    end
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (s.nrg_sync[1][p] == s.nrg_sync[2][p]) begin
        next_s.energy[p] = s.nrg_sync[2][p];
      end
    end
    next_s.int_reset = 1'b0;
    next_s.ack = req && !s.ack;
    next_s.rdata = '0;

    // register reads, only while the host interface is up
    if (req && !s.ack && !i_wb.we && s.st == ST_RUN) begin
      if (idx == IDX_MODE) begin
        next_s.rdata = {24'h0, s.mode_reg};
      end else if (idx == IDX_SLEEP) begin
        next_s.rdata = {24'h0, s.sleep_reg};
      end else if (idx == IDX_PHY_PD) begin
        next_s.rdata = {27'h0, s.phy_pd};
      end else if (idx == IDX_STATUS) begin
        next_s.rdata = {16'h0, 3'h0, s.energy, 4'h0, s.st, mode_f};
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (idx == port_idx(p)) begin
          next_s.rdata = {24'h0, s.port_ctl[p]};
        end
      end
    end

    // register writes; a new soft power-down mode steers the state on the same edge
    if (commit) begin
      if (idx == IDX_MODE) begin
        next_s.mode_reg = i_wb.dat[7:0];
      end else if (idx == IDX_SLEEP) begin
        next_s.sleep_reg = i_wb.dat[7:0];
      end else if (idx == IDX_PHY_PD) begin
        next_s.phy_pd = i_wb.dat[NUM_PORTS-1:0];
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (idx == port_idx(p)) begin
          next_s.port_ctl[p] = i_wb.dat[7:0];
        end
      end
    end

    // go-sleep timer: counts only while every cable is quiet
    if (s.st == ST_RUN && mode_f == MODE_ENERGY && !(|s.energy)) begin
      if (s.unit_cnt == UNIT_LAST) begin
        next_s.unit_cnt = '0;
        if (s.sleep_cnt != 9'h1FF) begin
          next_s.sleep_cnt = s.sleep_cnt + 9'h001;
        end
      end else begin
        next_s.unit_cnt = s.unit_cnt + CNT_W'(1);
      end
    end else begin
      next_s.unit_cnt = '0;
      next_s.sleep_cnt = '0;
    end

    // once-a-second link pulse; a started pulse always runs its full width
    if (s.pulse_cnt != 3'h0) begin
      next_s.pulse_cnt = s.pulse_cnt - 3'h1;
    end
    if (s.st == ST_LOW) begin
      if (s.sec_cnt == SEC_LAST) begin
        next_s.sec_cnt = '0;
        next_s.pulse_cnt = PULSE_LOAD;
      end else begin
        next_s.sec_cnt = s.sec_cnt + CNT_W'(1);
      end
    end else begin
      next_s.sec_cnt = '0;
    end

    case (s.st)
      ST_RUN: begin
        if (next_s.mode_reg[MODE_MSB:MODE_LSB] == MODE_SOFT_DOWN) begin
          next_s.st = ST_SOFT;
        end else if (mode_f == MODE_ENERGY && s.sleep_cnt > {1'b0, s.sleep_reg}) begin
          next_s.st = ST_LOW;
        end
      end
      ST_LOW: begin
        if (|s.energy) begin
          next_s.st = ST_RUN;
        end
      end
      ST_SOFT: begin
        // the waking access is acked but its write is dropped
        if (req && s.ack) begin
          next_s = regs_default(next_s);
          next_s.st = ST_RUN;
        end
      end
      ST_OFF: begin
        next_s = regs_default(next_s);
        if (s.pin_level) begin
          next_s.st = ST_RUN;
          next_s.int_reset = 1'b1;
        end
      end
      default: begin
        next_s.st = ST_RUN;
      end
    endcase

    // the pin overrides every mode
    if (!next_s.pin_level) begin
      next_s.st = ST_OFF;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // power gating outputs
  always_comb begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      port_off[p] = s.port_ctl[p][PORT_PD_BIT] || s.phy_pd[p];
    end
  end

  assign o_chip_power_en = s.pin_level && s.st != ST_OFF;
  assign o_int_reset = s.int_reset;
  assign o_pll_en = s.st == ST_RUN;
  assign o_mac_en = s.st == ST_RUN;
  assign o_host_en = s.st == ST_RUN;
  assign o_energy_det_en = s.st == ST_RUN || s.st == ST_LOW;
  assign o_link_pulse = s.pulse_cnt != 3'h0;
  assign o_phy_tx_en = (s.st == ST_RUN) ? ~port_off : '0;
  // saving drops a receiver only while its cable is quiet, so activity restores it
  assign o_phy_rx_en = o_phy_tx_en &
                       ~((mode_f == MODE_SAVING) ? (i_an_enable & ~s.energy) : '0);
  assign o_wb = {s.ack, s.rdata};

  // ==========================================================
  // assertions
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  mode_write_soft_a: assert property (
    (commit && idx == IDX_MODE && i_wb.dat[4:3] == 2'b10 && pin_hold) |=> !o_pll_en && !o_mac_en
  ) else $error("soft power-down write did not take effect next cycle");

  pin_down_a: assert property (
    (!i_chip_sleep_pin_n) [*6] |-> !o_chip_power_en
  ) else $error("chip not powered down with pin held low");

  pin_release_a: assert property (
    $rose(s.pin_level) |=> (s.st == ST_RUN && o_int_reset && mode_f == MODE_NORMAL) ##1 !o_int_reset
  ) else $error("pin release did not give one internal reset into normal mode");

  soft_wake_a: assert property (
    (s.st == ST_SOFT && req && s.ack && pin_hold) |=>
      (s.st == ST_RUN && s.mode_reg == MODE_RST && s.sleep_reg == SLEEP_RST && s.phy_pd == '0)
  ) else $error("soft power-down wake did not restore defaults");

  low_state_a: assert property (
    (s.st == ST_LOW) |-> (mode_f == MODE_ENERGY && !o_pll_en && o_energy_det_en && o_phy_tx_en == '0)
  ) else $error("low power state with wrong gating");

  sleep_entry_a: assert property (
    (s.st == ST_RUN && mode_f == MODE_ENERGY && s.sleep_cnt > {1'b0, s.sleep_reg}
     && !commit && pin_hold) |=> s.st == ST_LOW
  ) else $error("timeout passed without entering low power");

  energy_wake_a: assert property (
    (s.st == ST_LOW && (|s.energy) && pin_hold) |=> o_pll_en && o_mac_en
  ) else $error("cable energy did not wake the device");

  pulse_width_a: assert property (
    $rose(o_link_pulse) |-> o_link_pulse [*6] ##1 !o_link_pulse
  ) else $error("link pulse not six cycles wide");

  saving_rx_a: assert property (
    (s.st == ST_RUN && mode_f == MODE_SAVING && i_an_enable[0] && !s.energy[0] && !port_off[0])
      |-> (!o_phy_rx_en[0] && o_phy_tx_en[0] && o_pll_en && o_host_en)
  ) else $error("power saving gated port 0 wrongly");

  port_down_a: assert property (
    (commit && idx == port_idx(2) && i_wb.dat[PORT_PD_BIT] && pin_hold)
      |=> (!o_phy_tx_en[2] && !o_phy_rx_en[2] && o_pll_en)
  ) else $error("port control power-down did not stop port 2");

  // ==========================================================
  // bus contract and gating cross-checks
  ack_answer_a: assert property (
    (req && !o_wb.ack) |=> o_wb.ack
  ) else $error("bus request not acknowledged next cycle");

  ack_pulse_a: assert property (
    o_wb.ack |=> !o_wb.ack
  ) else $error("bus acknowledge held longer than one cycle");

  normal_run_a: assert property (
    (s.st == ST_RUN && mode_f == MODE_NORMAL)
      |-> (o_pll_en && o_mac_en && o_host_en && o_phy_rx_en == o_phy_tx_en)
  ) else $error("normal mode gated a block");

  mode_follow_a: assert property (
    (commit && idx == IDX_MODE && pin_hold) |=> s.mode_reg == $past(wdata)
  ) else $error("mode write did not land");

  sleep_mode_only_a: assert property (
    (s.st == ST_RUN && mode_f != MODE_ENERGY) |=> s.st != ST_LOW
  ) else $error("low power state entered outside energy detect mode");

  read_zero_a: assert property (
    (req && !o_wb.ack && s.st != ST_RUN) |=> o_wb.dat == '0
  ) else $error("register read answered while host interface down");

  soft_gate_a: assert property (
    (s.st == ST_SOFT) |-> (!o_pll_en && !o_mac_en && !o_host_en && o_phy_tx_en == '0)
  ) else $error("soft power-down left a block running");

  soft_stay_a: assert property (
    (s.st == ST_SOFT && !req && pin_hold) |=> s.st == ST_SOFT
  ) else $error("soft power-down left without a host access");

  saving_cause_a: assert property (
    (o_phy_tx_en[0] && !o_phy_rx_en[0])
      |-> (mode_f == MODE_SAVING && i_an_enable[0] && !s.energy[0])
  ) else $error("receiver dropped outside power saving conditions");

  saving_keep_a: assert property (
    (s.st == ST_RUN && mode_f == MODE_SAVING && !commit && pin_hold)
      |=> ($stable(s.sleep_reg) && $stable(s.port_ctl) && o_host_en)
  ) else $error("power saving lost register contents");

  phy_pd_a: assert property (
    s.phy_pd[1] |-> (!o_phy_tx_en[1] && !o_phy_rx_en[1])
  ) else $error("management power-down did not stop port 1");

  pulse_low_a: assert property (
    $rose(o_link_pulse) |-> $past(s.st) == ST_LOW
  ) else $error("link pulse started outside low power state");

  pin_off_a: assert property (
    !s.pin_level |-> (s.st == ST_OFF && !o_chip_power_en && !o_pll_en)
  ) else $error("pin low without full power-down");

  int_reset_a: assert property (
    o_int_reset |-> (s.st == ST_RUN && s.mode_reg == MODE_RST && s.sleep_reg == SLEEP_RST)
  ) else $error("internal reset without register defaults");

  soft_enter_c: cover property (s.st == ST_RUN ##1 s.st == ST_SOFT ##[1:20] s.st == ST_RUN);
  low_enter_c: cover property (s.st == ST_RUN ##1 s.st == ST_LOW);
  pulse_c: cover property ($rose(o_link_pulse));
  saving_c: cover property (mode_f == MODE_SAVING && o_phy_tx_en[0] && !o_phy_rx_en[0]);
  pin_c: cover property ($rose(s.pin_level));

endmodule

// [sw_pwr_pkg.sv]
package sw_pwr_pkg;

  // ==========================================================
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_NS = 20;
  localparam int PULSE_NS = 120;
  localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SECOND_S = 1;
  localparam int SECOND_CYC_DEF = SECOND_S * CLK_HZ;
  localparam int SLEEP_UNIT_US = 1000;
  localparam int SLEEP_UNIT_CYC_DEF = SLEEP_UNIT_US * (CLK_HZ / 1_000_000);
  localparam int CNT_W = 26;
  localparam int NUM_PORTS = 5;

  // ==========================================================
  // register map (word index, byte address is four times it)
  localparam logic [7:0] IDX_MODE = 8'h0E;
  localparam logic [7:0] IDX_SLEEP = 8'h0F;
  localparam logic [7:0] IDX_PORT_CTL13 = 8'h1D;
  localparam int PORT_STRIDE = 16;
  localparam logic [7:0] IDX_PHY_PD = 8'h60;
  localparam logic [7:0] IDX_STATUS = 8'h61;
  localparam int MODE_LSB = 3;
  localparam int MODE_MSB = 4;
  localparam int PORT_PD_BIT = 3;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] SLEEP_RST = 8'h50;
  localparam logic [2:0] PULSE_LOAD = 3'(PULSE_CYC);

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_ENERGY = 2'b01,
    MODE_SOFT_DOWN = 2'b10,
    MODE_SAVING = 2'b11
  } pwr_mode_e;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_LOW = 2'b01,
    ST_SOFT = 2'b10,
    ST_OFF = 2'b11
  } pwr_state_e;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [9:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_s;

  typedef struct packed {
    pwr_state_e st;
    logic [7:0] mode_reg;
    logic [7:0] sleep_reg;
    logic [NUM_PORTS-1:0][7:0] port_ctl;
    logic [NUM_PORTS-1:0] phy_pd;
    logic [2:0] pin_sync;
    logic pin_level;
    logic [2:0][NUM_PORTS-1:0] nrg_sync;
    logic [NUM_PORTS-1:0] energy;
    logic ack;
    logic [31:0] rdata;
    logic [CNT_W-1:0] unit_cnt;
    logic [8:0] sleep_cnt;
    logic [CNT_W-1:0] sec_cnt;
    logic [2:0] pulse_cnt;
    logic int_reset;
  } state_s;

  localparam state_s STATE_RST = '{st: ST_RUN, mode_reg: MODE_RST, sleep_reg: SLEEP_RST,
                                   pin_sync: 3'b111, pin_level: 1'b1, default: '0};

  function automatic logic [7:0] port_idx(input int p);
    port_idx = IDX_PORT_CTL13 + 8'(PORT_STRIDE * p);
  endfunction

endpackage

// [testbench.sv]
`timescale 1ns/1ps

module testbench;
  import sw_pwr_pkg::*;

  localparam int SEC = 40;
  localparam int UNIT = 4;
  logic i_clk;
  logic i_rst;
  wb_req_s i_wb;
  wb_rsp_s o_wb;
  logic i_chip_sleep_pin_n;
  logic [NUM_PORTS-1:0] i_cable_energy;
  logic [NUM_PORTS-1:0] i_an_enable;
  logic o_chip_power_en, o_int_reset, o_pll_en, o_mac_en, o_host_en;
  logic o_energy_det_en, o_link_pulse;
  logic [NUM_PORTS-1:0] o_phy_tx_en, o_phy_rx_en;
  logic [31:0] q;
  int errors = 0;
  int checked = 0;
  int n;

  sw_power_ctrl #(.SECOND_CYC(SEC), .SLEEP_UNIT_CYC(UNIT)) uut (
    .i_clk(i_clk), .i_rst(i_rst), .i_wb(i_wb), .o_wb(o_wb),
    .i_chip_sleep_pin_n(i_chip_sleep_pin_n), .i_cable_energy(i_cable_energy),
    .i_an_enable(i_an_enable), .o_chip_power_en(o_chip_power_en),
    .o_int_reset(o_int_reset), .o_pll_en(o_pll_en), .o_mac_en(o_mac_en),
    .o_host_en(o_host_en), .o_energy_det_en(o_energy_det_en),
    .o_link_pulse(o_link_pulse), .o_phy_tx_en(o_phy_tx_en), .o_phy_rx_en(o_phy_rx_en)
  );

  // ==========================================================
  // helpers
  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  // classic single cycle; holds until ack is sampled high
  task automatic wb(input logic we, input logic [9:0] a, input logic [7:0] d);
    i_wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: {24'h0, d}};
    do begin
      @(posedge i_clk);
    end while (o_wb.ack !== 1'b1);
    q = o_wb.dat;
    i_wb <= '0;
    @(posedge i_clk);
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    wb(1'b0, a, 8'h00);
    chk(q, {24'h0, e});
  endtask

  // the ack edge is the one just before the idle edge the task ends on
  task automatic wr_mode(input logic [1:0] m);
    wb(1'b1, 10'h038, {3'b000, m, 3'b000});
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    end_sim;
  end

  // ==========================================================
  // tests
  initial begin
    i_rst = 1'b1;
    i_wb = '0;
    i_chip_sleep_pin_n = 1'b1;
    i_cable_energy = 5'h1F;
    i_an_enable = 5'h1F;
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rd(10'h038, 8'h00);
    rd(10'h03C, SLEEP_RST);
    rd(10'h074, 8'h00);
    rd(10'h3FC, 8'h00);
    chk({o_pll_en, o_mac_en, o_host_en, o_phy_tx_en}, 32'hFF);
    done("reset");
    wb(1'b1, 10'h0F4, 8'h08);
    chk(o_phy_tx_en, 32'h1B);
    rd(10'h0F4, 8'h08);
    wb(1'b1, 10'h180, 8'h02);
    chk(o_phy_tx_en, 32'h19);
    wb(1'b1, 10'h0F4, 8'h00);
    wb(1'b1, 10'h180, 8'h00);
    chk(o_phy_tx_en, 32'h1F);
    done("port");
    wb(1'b1, 10'h03C, 8'h33);
    wr_mode(2'b10);
    chk({o_pll_en, o_mac_en, o_phy_tx_en}, 32'h0);
    wb(1'b1, 10'h03C, 8'h11);
    chk(q, 32'h0);
    chk(o_pll_en, 32'h1);
    rd(10'h038, 8'h00);
    rd(10'h03C, SLEEP_RST);
    done("soft");
    wb(1'b1, 10'h03C, 8'h02);
    i_cable_energy <= 5'h00;
    wr_mode(2'b01);
    n = 0;
    while (o_pll_en !== 1'b0 && n < 200) begin
      @(posedge i_clk);
      n++;
    end
    chk((n > 10) && (n < 200), 32'h1);
    chk({o_pll_en, o_mac_en, o_host_en, o_energy_det_en, o_phy_tx_en}, 32'h20);
    rd(10'h03C, 8'h00);
    n = 0;
    while (o_link_pulse !== 1'b1 && n < 100) begin
      @(posedge i_clk);
      n++;
    end
    n = 0;
    while (o_link_pulse === 1'b1 && n < 20) begin
      @(posedge i_clk);
      n++;
    end
    chk(n, PULSE_CYC);
    i_cable_energy <= 5'h04;
    n = 0;
    while (o_pll_en !== 1'b1 && n < 10) begin
      @(posedge i_clk);
      n++;
    end
    chk(o_pll_en, 32'h1);
    wb(1'b0, 10'h184, 8'h00);
    chk(q, 32'h401);
    done("energy");
    i_cable_energy <= 5'h1E;
    wr_mode(2'b11);
    repeat (5) @(posedge i_clk);
    chk({o_pll_en, o_mac_en, o_host_en, o_phy_tx_en, o_phy_rx_en}, 32'h1FFE);
    rd(10'h03C, 8'h02);
    i_cable_energy <= 5'h1F;
    repeat (5) @(posedge i_clk);
    chk(o_phy_rx_en, 32'h1F);
    wr_mode(2'b00);
    rd(10'h038, 8'h00);
    done("saving");
    wr_mode(2'b11);
    i_chip_sleep_pin_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    chk(o_chip_power_en, 32'h0);
    i_chip_sleep_pin_n <= 1'b1;
    n = 0;
    while (o_int_reset !== 1'b1 && n < 10) begin
      @(posedge i_clk);
      n++;
    end
    chk(o_int_reset, 32'h1);
    @(posedge i_clk);
    chk({o_chip_power_en, o_int_reset}, 32'h2);
    rd(10'h038, 8'h00);
    done("pin");
    end_sim;
  end
endmodule
